// [hdl/touch_cal_consts.svh]
`ifndef TOUCH_CAL_CONSTS_SVH
`define TOUCH_CAL_CONSTS_SVH

// register offsets on the host register port
`define OFS_SAMPLING_CFG  8'h0F
`define OFS_CAL_CFG       8'h10
`define OFS_FORCE_LO      8'h11
`define OFS_FORCE_HI      8'h12
`define OFS_NOISE_THR     8'h13
`define OFS_NOISE_LO      8'h14
`define OFS_NOISE_HI      8'h15
`define OFS_NEG_THR       8'h17

// field positions
`define SC_LSB            4
`define ST_LSB            2
`define CDS_LSB           0
`define CSC_LSB           4
`define NDC_LSB           0
`define NEGATIVE_CALIBRATE_THRESHOLD_LSB          4
`define NEGATIVE_DELTA_THRESHOLD_LSB          0

// reset values
`define RST_SAMPLING_CFG  8'h24
`define RST_CAL_CFG       8'h30
`define RST_FORCE         8'h00
`define RST_NOISE_THR     8'h32
`define RST_NEG_THR       8'h09
`define RST_CAL_LEFT      9'h010

// write masks for bits that exist
`define MASK_CAL_CFG      8'h73
`define MASK_HI3          8'h07

// timing
`define CLK_FREQ_HZ       25000000
`define CYC_DELAY_STEP_MS 10
`define CYC_DELAY_STEP_CYC (`CLK_FREQ_HZ / 1000 * `CYC_DELAY_STEP_MS)

// counts and limits
`define KEY_COUNT         11
`define LAST_SLOT         4'hF
`define NEGATIVE_CALIBRATE_THRESHOLD_MAX          4'hC
`define NEGATIVE_CALIBRATE_THRESHOLD_STEP         8'h0A
`define NEG_CNT_BASE      6'h04

`endif

// [hdl/touch_cal_pkg.sv]
package touch_cal_pkg;

  localparam int SAMPLE_W = 12;

  // one conversion request to the analogue front end
  typedef struct packed {
    logic       start;
    logic [3:0] chan;
    logic [3:0] units;
  } afe_req_s;

  // one conversion result from the analogue front end
  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] value;
  } afe_rsp_s;

  // host register port access
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [2:0] {
    ST_DELAY = 3'b001,
    ST_REQ   = 3'b010,
    ST_WAIT  = 3'b100
  } scan_state_e;

endpackage

// [hdl/touch_cal.sv]
// Notes on behaviour
// - each channel averages sample-count code plus one samples, 1 to 16
// - sampling-time code 0..3 gives 1, 2, 4 or 8 time units
// - sixteen slots form one scan cycle; cycle delay 0, 10, 20 or 30 ms
// - calibration takes two to the power of code plus one samples
// - negative hits counted 4, 8, 16 or 32 times force recalibration
// - writing 1 to a force bit calibrates that key; bit clears itself
// - noise threshold register holds 0..255, resets to 50
// - successive-sample difference above noise threshold sets noise flag
// - eleven read-only noise flags, keys 8..10 in low bits of second
// - negative calibrate code 0 disables, 1..12 give -10..-120
// - negative delta code n gives -(n+1), codes 14 and 15 give -15
// - variation at or beyond enabled calibrate threshold recalibrates at once
`timescale 1ns/1ps
`include "touch_cal_consts.svh"

module touch_cal
  import touch_cal_pkg::*;
#(
  parameter int DELAY_STEP_CYC = `CYC_DELAY_STEP_CYC,
  parameter int KEYS           = `KEY_COUNT
)
(
  input  logic     sys_clk,
  input  logic     sys_rst,
  input  logic     clk_en,
  input  reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  output afe_req_s afe_req,
  input  afe_rsp_s afe_rsp
);

  localparam int SW = SAMPLE_W;

  // true when delta reaches the negative limit
  // the limit is widened to the delta width before negation so that
  // the largest calibrate limit of 120 never wraps to a positive value
  function automatic logic below_neg(
    input logic signed [SW:0] d,
    input logic [7:0]         lim
  );
    below_neg = d <= -$signed({{(SW-7){1'b0}}, lim});
  endfunction

  // configuration registers
  logic [7:0]  samp_cfg_r;
  logic [7:0]  cal_cfg_r;
  logic [7:0]  noise_thr_r;
  logic [7:0]  neg_thr_r;
  logic [10:0] force_cal_key_r;
  logic [10:0] key_noise_flag_r;
  logic [7:0]  rdata_r;

  // scan sequencer state
  scan_state_e state_r;
  scan_state_e state_nxt;
  logic [3:0]  slot_r;
  logic [3:0]  cnt_r;
  logic [15:0] sum_r;
  logic [19:0] delay_r;
  afe_req_s    afe_req_r;

  // per-key memories
  logic [SW-1:0] baseline_r [KEYS];
  logic [SW-1:0] prev_r     [KEYS];
  logic [5:0]    ncnt_r     [KEYS];
  logic [8:0]    cal_left_r [KEYS];
  logic [19:0]   cal_acc_r  [KEYS];

  // register fields
  wire [3:0] average_sample_count     = samp_cfg_r[`SC_LSB +: 4];
  wire [1:0] channel_sampling_time    = samp_cfg_r[`ST_LSB +: 2];
  wire [1:0] cycle_delay_select       = samp_cfg_r[`CDS_LSB +: 2];
  wire [2:0] calibration_sample_count = cal_cfg_r[`CSC_LSB +: 3];
  wire [1:0] negative_hit_count       = cal_cfg_r[`NDC_LSB +: 2];
  wire [3:0] negative_calibrate_threshold = neg_thr_r[`NEGATIVE_CALIBRATE_THRESHOLD_LSB +: 4];
  wire [3:0] negative_delta_threshold     = neg_thr_r[`NEGATIVE_DELTA_THRESHOLD_LSB +: 4];
  wire [7:0] noise_threshold_value        = noise_thr_r;

  // offset decode shared by write strobes and read selection
  wire sel_samp  = reg_req.addr == `OFS_SAMPLING_CFG;
  wire sel_cal   = reg_req.addr == `OFS_CAL_CFG;
  wire sel_flo   = reg_req.addr == `OFS_FORCE_LO;
  wire sel_fhi   = reg_req.addr == `OFS_FORCE_HI;
  wire sel_noise = reg_req.addr == `OFS_NOISE_THR;
  wire sel_nlo   = reg_req.addr == `OFS_NOISE_LO;
  wire sel_nhi   = reg_req.addr == `OFS_NOISE_HI;
  wire sel_neg   = reg_req.addr == `OFS_NEG_THR;

  // register port write strobes; the flag registers take no writes
  wire wr_samp  = reg_req.wr & sel_samp;
  wire wr_cal   = reg_req.wr & sel_cal;
  wire wr_flo   = reg_req.wr & sel_flo;
  wire wr_fhi   = reg_req.wr & sel_fhi;
  wire wr_noise = reg_req.wr & sel_noise;
  wire wr_neg   = reg_req.wr & sel_neg;

  // read data selection, unmapped offsets read zero
  // spare bits above the eleventh key always read zero
  wire [7:0] rd_mux =
    sel_samp  ? samp_cfg_r :
    sel_cal   ? cal_cfg_r :
    sel_flo   ? force_cal_key_r[7:0] :
    sel_fhi   ? {5'h00, force_cal_key_r[10:8]} :
    sel_noise ? noise_thr_r :
    sel_nlo   ? key_noise_flag_r[7:0] :
    sel_nhi   ? {5'h00, key_noise_flag_r[10:8]} :
    sel_neg   ? neg_thr_r : 8'h00;

  // sample accumulation and averaging
  // sixteen twelve-bit samples fit the sixteen-bit sum without overflow
  // slots 11 to 15 are converted for timing but never evaluated
  wire        rsp_take  = (state_r == ST_WAIT) & afe_rsp.valid;
  wire        last_smp  = cnt_r == average_sample_count;
  wire [15:0] sum_fin   = sum_r + {4'h0, afe_rsp.value};
  wire [15:0] div_n     = {11'h000, {1'b0, average_sample_count} + 5'h01};
  wire [15:0] avg_full  = sum_fin / div_n;
  wire [SW-1:0] avg     = avg_full[SW-1:0];
  wire        is_key    = {28'h0, slot_r} < KEYS;
  wire [3:0]  idx       = is_key ? slot_r : 4'h0;
  wire        eval_fire = rsp_take & last_smp & is_key;
  wire        scan_end  = rsp_take & last_smp & (slot_r == `LAST_SLOT);

  // cycle delay load, zero code skips the wait
  wire [19:0] delay_load =
    20'({30'h0, cycle_delay_select} * DELAY_STEP_CYC);

  // variation of the averaged value against the stored baseline
  wire [SW-1:0] base = baseline_r[idx];
  wire signed [SW:0] delta =
    $signed({1'b0, avg}) - $signed({1'b0, base});

  // negative delta threshold: -(code+1), codes 14 and 15 both -15
  // reaching the limit counts as a hit, not only passing it
  wire [7:0] negative_delta_threshold_lim = (negative_delta_threshold == 4'hF) ?
    8'h0F : {4'h0, negative_delta_threshold} + 8'h01;
  wire neg_hit = below_neg(delta, negative_delta_threshold_lim);

  // negative calibrate threshold: 0 off, 1..12 steps of ten
  // codes 13 to 15 have no meaning and behave as disabled
  wire negative_calibrate_threshold_en = (negative_calibrate_threshold != 4'h0) &
    (negative_calibrate_threshold <= `NEGATIVE_CALIBRATE_THRESHOLD_MAX);
  wire [7:0] negative_calibrate_threshold_lim =
    8'({4'h0, negative_calibrate_threshold} * `NEGATIVE_CALIBRATE_THRESHOLD_STEP);
  wire negative_calibrate_threshold_hit = negative_calibrate_threshold_en & below_neg(delta, negative_calibrate_threshold_lim);

  // consecutive negative hits reaching the selected count
  wire [5:0] ncnt_lim = `NEG_CNT_BASE << negative_hit_count;
  wire [5:0] ncnt_inc = ncnt_r[idx] + 6'h01;
  wire       ncnt_full = neg_hit & (ncnt_inc >= ncnt_lim);

  // noise: difference to the previous averaged value
  // the flag is rewritten every scan, so it clears once a key is quiet
  wire [SW-1:0] prev = prev_r[idx];
  wire [SW-1:0] noise_diff = (avg >= prev) ? avg - prev : prev - avg;
  wire noisy = {{(SW-8){1'b0}}, noise_threshold_value} < noise_diff;

  // calibration bookkeeping for the key being evaluated
  wire       cal_run   = cal_left_r[idx] != 9'h000;
  wire       force_bit = force_cal_key_r[idx];
  wire       start_cal = force_bit | (~cal_run & (negative_calibrate_threshold_hit | ncnt_full));
  wire [8:0] cal_total = 9'h002 << calibration_sample_count;
  wire [19:0] cal_acc_nxt = cal_acc_r[idx] + {8'h00, avg};
  wire [19:0] cal_base =
    cal_acc_nxt >> ({2'h0, calibration_sample_count} + 5'h01);

  // force bits: software write of one sets, evaluation clears, set wins
  wire [10:0] force_set = {wr_fhi ? reg_req.wdata[2:0] : 3'h0,
                           wr_flo ? reg_req.wdata : 8'h00};
  wire [10:0] force_clr = eval_fire ? (11'h001 << idx) : 11'h000;
  wire [10:0] force_nxt =
    (force_cal_key_r & ~force_clr) | force_set;

  // scan sequencer next state
  // only one conversion is outstanding; results outside the wait state
  // are ignored so a stray valid cannot skip a sample
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_DELAY:
        if (delay_r == 20'h00000)
          state_nxt = ST_REQ;
      ST_REQ:
        state_nxt = ST_WAIT;
      ST_WAIT:
        if (scan_end)
          state_nxt = ST_DELAY;
        else if (afe_rsp.valid)
          state_nxt = ST_REQ;
      default:
        state_nxt = ST_DELAY;
    endcase
  end

  // configuration registers
  // threshold values above 127 are stored as written and compared whole
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      samp_cfg_r  <= `RST_SAMPLING_CFG;
      cal_cfg_r   <= `RST_CAL_CFG;
      noise_thr_r <= `RST_NOISE_THR;
      neg_thr_r   <= `RST_NEG_THR;
    end
    else if (clk_en)
    begin
      if (wr_samp)
        samp_cfg_r <= reg_req.wdata;
      if (wr_cal)
        cal_cfg_r <= reg_req.wdata & `MASK_CAL_CFG;
      if (wr_noise)
        noise_thr_r <= reg_req.wdata;
      if (wr_neg)
        neg_thr_r <= reg_req.wdata;
    end
  end

  // force bits, noise flags and registered read data
  // a new write of one in the servicing cycle wins over the clear
  // read data holds until the next read strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      force_cal_key_r  <= {3'h0, `RST_FORCE};
      key_noise_flag_r <= 11'h000;
      rdata_r          <= 8'h00;
    end
    else if (clk_en)
    begin
      force_cal_key_r <= force_nxt;
      if (eval_fire)
        key_noise_flag_r[idx] <= noisy;
      if (reg_req.rd)
        rdata_r <= rd_mux;
    end
  end

  // sequencer state, slot and sample counters
  // the slot wraps from 15 to 0, which starts the next scan cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_DELAY;
      slot_r  <= 4'h0;
      cnt_r   <= 4'h0;
      sum_r   <= 16'h0000;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      if (rsp_take)
      begin
        cnt_r <= last_smp ? 4'h0 : cnt_r + 4'h1;
        sum_r <= last_smp ? 16'h0000 : sum_fin;
        if (last_smp)
          slot_r <= slot_r + 4'h1;
      end
    end
  end

  // cycle delay counter between scan cycles
  // loaded once per scan; a zero load passes through in one cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      delay_r <= 20'h00000;
    else if (clk_en)
    begin
      if (scan_end)
        delay_r <= delay_load;
      else if (state_r == ST_DELAY && delay_r != 20'h00000)
        delay_r <= delay_r - 20'h00001;
    end
  end

  // conversion request to the front end
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      afe_req_r <= '0;
    else if (clk_en)
    begin
      afe_req_r.start <= state_r == ST_REQ;
      // channel and time load only with a request, so they stand while
      // the front end converts and through the delay between scans
      if (state_r == ST_REQ)
      begin
        afe_req_r.chan  <= slot_r;
        afe_req_r.units <= 4'h1 << channel_sampling_time;
      end
    end
  end

  // per-key baseline, calibration and negative tracking
  // every key calibrates after reset before negative detection starts
  // negative detection pauses while a key is calibrating
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int k = 0; k < KEYS; k++)
      begin
        baseline_r[k] <= '0;
        prev_r[k]     <= '0;
        ncnt_r[k]     <= 6'h00;
        cal_left_r[k] <= `RST_CAL_LEFT;
        cal_acc_r[k]  <= 20'h00000;
      end
    end
    else if (clk_en && eval_fire)
    begin
      prev_r[idx] <= avg;
      if (start_cal)
      begin
        cal_left_r[idx] <= cal_total;
        cal_acc_r[idx]  <= 20'h00000;
        ncnt_r[idx]     <= 6'h00;
      end
      else if (cal_run)
      begin
        cal_acc_r[idx]  <= cal_acc_nxt;
        cal_left_r[idx] <= cal_left_r[idx] - 9'h001;
        if (cal_left_r[idx] == 9'h001)
          baseline_r[idx] <= cal_base[SW-1:0];
      end
      else
        ncnt_r[idx] <= neg_hit ? ncnt_inc : 6'h00;
    end
  end

  // outputs, both straight from flops
  assign reg_rdata = rdata_r;
  assign afe_req   = afe_req_r;

endmodule // touch_cal

// [testbench/touch_cal_checker.sv]
`timescale 1ns/1ps
module touch_cal_checker
  import touch_cal_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire reg_req_s   reg_req,
  input wire logic [7:0] reg_rdata,
  input wire afe_req_s   afe_req,
  input wire afe_rsp_s   afe_rsp
);
  // register strobes that the design really takes
  wire rd_q = reg_req.rd & clk_en;
  wire wr_q = reg_req.wr & clk_en;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  start_pulse_a: assert property (afe_req.start |=> !afe_req.start)
    else $error("start longer than one cycle");
  units_code_a: assert property (afe_req.start |-> $onehot(afe_req.units))
    else $error("sampling time not 1, 2, 4 or 8");
  valid_gap_a: assert property (afe_rsp.valid && clk_en |=> !afe_req.start)
    else $error("start right after a result");
  chan_hold_a: assert property ($changed(afe_req.chan) |-> afe_req.start)
    else $error("slot moved without a start");
  rdata_hold_a: assert property (!rd_q |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  noise_hi_a: assert property (rd_q && reg_req.addr == 8'h15 |=>
    reg_rdata[7:3] == 5'h00) else $error("noise flag high bits set");
  cal_mask_a: assert property (rd_q && reg_req.addr == 8'h10 |=>
    (reg_rdata & 8'h8C) == 8'h00) else $error("calibration spare bits set");
  force_hi_a: assert property (rd_q && reg_req.addr == 8'h12 |=>
    reg_rdata[7:3] == 5'h00) else $error("force high spare bits set");
  thr_echo_a: assert property (wr_q && reg_req.addr == 8'h13 ##2
    rd_q && reg_req.addr == 8'h13 |=> reg_rdata == $past(reg_req.wdata, 3))
    else $error("noise threshold not read back");

  cover property (afe_req.start && afe_req.chan == 4'hF);
  cover property (wr_q && reg_req.addr == 8'h11);
  cover property (rd_q && reg_req.addr == 8'h14 ##1 reg_rdata != 8'h00);
endmodule // touch_cal_checker

bind touch_cal touch_cal_checker chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .afe_req(afe_req), .afe_rsp(afe_rsp));

// [testbench/afe_model.sv]
`timescale 1ns/1ps
module afe_model
  import touch_cal_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire afe_req_s req,
  output afe_rsp_s      rsp
);
  logic [11:0] lvl [16];
  int          left = -1;
  wire         fire = !req.start && left == 0;

  initial
  begin
    rsp = '0;
    for (int k = 0; k < 16; k++)
      lvl[k] = 12'h000;
  end

  // answer each start 2..5 cycles after it rises; value is junk outside valid
  always @(posedge sys_clk)
  begin
    rsp.valid <= fire;
    rsp.value <= fire ? lvl[req.chan] : ~rsp.value;
    left <= req.start ? $urandom_range(3, 0) : (left >= 0 ? left - 1 : -1);
  end
endmodule // afe_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  import touch_cal_pkg::*;
  localparam int STEP = 20;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clk_en = 1'b1;
  reg_req_s   reg_req = '0;
  logic [7:0] reg_rdata, rd_v, d;
  afe_req_s   afe_req;
  afe_rsp_s   afe_rsp;
  int         n_errors = 0;
  int         check_count = 0;
  int         idle_n = 0;
  int         n0, gap, gap0;
  logic [3:0] sc;
  logic [7:0] rst_tab [9] = '{8'h24, 8'h30, 0, 0, 8'h32, 0, 0, 0, 8'h09};
  logic [7:0] rw_ofs [7] = '{8'h0F, 8'h10, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};

  touch_cal #(.DELAY_STEP_CYC(STEP), .KEYS(11)) dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .afe_req(afe_req), .afe_rsp(afe_rsp));
  afe_model ana (.sys_clk(sys_clk), .req(afe_req), .rsp(afe_rsp));

  initial forever #20 sys_clk = ~sys_clk;
  // cycles since the last conversion result
  always @(negedge sys_clk) idle_n <= afe_rsp.valid ? 0 : idle_n + 1;

  function automatic logic [7:0] mask(input logic [7:0] a);
    return (a == 8'h10) ? 8'h73 : (a > 8'h13 && a < 8'h17) ? 8'h00 : 8'hFF;
  endfunction

  task automatic summarize;
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one register access; read data lands after the strobe edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    reg_req = '{w, ~w, a, v};
    @(negedge sys_clk);
    rd_v = reg_rdata;
    reg_req = '0;
    @(negedge sys_clk);
  endtask

  task automatic next_start;
    repeat (20000)
    begin
      @(negedge sys_clk);
      if (afe_req.start === 1'b1)
        return;
    end
    n_errors++;
    summarize();
  endtask

  // runs to the second slot of the next scan, counting slot 0 samples
  task automatic probe(input logic [1:0] st);
    repeat (400)
    begin
      next_start();
      if (afe_req.chan === 4'hF)
        break;
    end
    `CHK("slot15", 4'hF, afe_req.chan)
    repeat (20)
    begin
      next_start();
      if (afe_req.chan !== 4'hF)
        break;
    end
    gap = idle_n;
    n0 = 1;
    repeat (20)
    begin
      next_start();
      if (afe_req.chan !== 4'h0)
        break;
      n0++;
    end
    `CHK("units", 4'h1 << st, afe_req.units)
  endtask

  initial
  begin
    void'($urandom(32'hC30B));
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
    // reset values, offset 0x16 is unmapped
    for (int i = 0; i < 9; i++)
    begin
      acc(0, 8'h0F + 8'(i), 8'h00);
      `CHK("reset", rst_tab[i], rd_v)
    end
    // random writes read back through the field masks
    for (int i = 0; i < 7; i++)
    begin
      d = 8'($urandom) & ((rw_ofs[i] == 8'h13) ? 8'h7F : 8'hFF);
      acc(1, rw_ofs[i], d);
      acc(0, rw_ofs[i], 8'h00);
      `CHK("rw", d & mask(rw_ofs[i]), rd_v)
    end
    // a write with the clock enable low is lost
    acc(1, 8'h13, 8'h0A);
    clk_en = 1'b0;
    acc(1, 8'h13, 8'h55);
    clk_en = 1'b1;
    acc(0, 8'h13, 8'h00);
    `CHK("hold", 8'h0A, rd_v)
    // sample count, sampling time and cycle delay sweep
    for (int i = 0; i < 4; i++)
    begin
      sc = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
      acc(1, 8'h0F, {sc, 2'(i), 2'(i)});
      probe(2'(i));
      probe(2'(i));
      if (i == 0)
        gap0 = gap;
      `CHK("samples", 5'(sc) + 5'h01, 5'(n0))
      `CHK("delay", i * STEP, gap - gap0)
    end
    // noise flags follow the latest difference against the threshold
    acc(1, 8'h0F, 8'h00);
    for (int k = 0; k < 16; k++)
      ana.lvl[k] = 12'h400;
    repeat (3) probe(0);
    ana.lvl[3] = 12'h440;
    ana.lvl[5] = 12'h40A;
    ana.lvl[9] = 12'h40B;
    probe(0);
    acc(0, 8'h14, 8'h00);
    `CHK("noise_lo", 8'h08, rd_v)
    acc(0, 8'h15, 8'h00);
    `CHK("noise_hi", 8'h02, rd_v)
    probe(0);
    acc(0, 8'h14, 8'h00);
    `CHK("quiet", 8'h00, rd_v)
    // force bits stay until their key is serviced, then clear
    acc(1, 8'h11, 8'h01);
    acc(1, 8'h12, 8'h04);
    acc(0, 8'h11, 8'h00);
    `CHK("force_set", 8'h01, rd_v)
    probe(0);
    acc(0, 8'h11, 8'h00);
    `CHK("force_lo", 8'h00, rd_v)
    acc(0, 8'h12, 8'h00);
    `CHK("force_hi", 8'h00, rd_v)
    summarize();
  end
endmodule // testbench
